// file: pd_irq_defs.svh
`ifndef PD_IRQ_DEFS_SVH
`define PD_IRQ_DEFS_SVH

// register offsets
`define ADDR_BASIC_CTRL   5'h00
`define ADDR_IRQ_CTRL     5'h11
`define ADDR_IRQ_STAT     5'h12
`define ADDR_ED_CTRL      5'h1D

// field positions
`define BC_PWRDN_BIT      11
`define IC_OE_BIT         0
`define IC_EN_BIT         1
`define MASK_LINK_BIT     5
`define MASK_ED_BIT       6
`define ED_EN_BIT         15
`define ED_LP_BIT         0

// reset values
`define RST_BASIC_CTRL    16'h0000
`define RST_IRQ_CTRL      2'h0
`define RST_IRQ_MASK      8'h00
`define RST_IRQ_STAT      8'h00
`define RST_ED_EN         1'b0

// timing
`define CLK_MHZ           100
`define ED_PULSE_PERIOD_US 1000
`define ED_PULSE_WIDTH_NS 100
`define ED_WAKE_TIME_US   100
`define ED_IDLE_TIME_US   50

`endif

// file: pd_irq_pkg.sv
package pd_irq_pkg;

  // one register access from software
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // energy-detect power state
  typedef enum logic [1:0] {
    ED_NORMAL = 2'b00,
    ED_SLEEP  = 2'b01,
    ED_WAKE   = 2'b10
  } ed_state_t;

endpackage

// file: powerdown_interrupt_pin_logic.sv
// How it works
// - after reset the shared pin is a power-down input, interrupts off
// - output-enable bit 0 of irq control turns pin into low irq output
// - pin held low as input powers down like basic control bit 11
// - weak pull-up holds pin high; outside logic may pull it low
// - pin pulled low at start brings the device up powered down
// - registers stay live in power-down; output-enable bit exits pin-driven power-down, not bit 11
// - every interrupt source is disabled after reset
// - irq enable bit 1 gates pin; low mask byte gates each source
// - pending unmasked interrupt pulls the pin low without waiting
// - upper status byte shows every pending source, several at once
// - reading status clears all pending bits except any set in the same cycle, and releases the pin
// - energy detect with idle cable keeps low power, watching line
// - line activity in low power starts normal power-up sequence
// - energy detect wakes transmitter periodically for pulses
// - energy detect is steered by its own control register
`timescale 1ns/1ps
`include "pd_irq_defs.svh"

module powerdown_interrupt_pin_logic #(
  parameter int unsigned CNT_W     = 20,
  parameter int unsigned PERIOD_CYC =
    `ED_PULSE_PERIOD_US * `CLK_MHZ,
  parameter int unsigned WAKE_CYC  =
    `ED_WAKE_TIME_US * `CLK_MHZ,
  parameter int unsigned IDLE_CYC  =
    `ED_IDLE_TIME_US * `CLK_MHZ
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire pd_irq_pkg::reg_req_t req,
  output logic [15:0]            rdata,
  input  wire logic              pin_i,
  output logic                   pin_o,
  output logic                   pin_oe,
  output logic                   pullup_en,
  input  wire logic              link_up,
  input  wire logic              line_energy,
  input  wire logic [7:0]        ext_evt,
  output logic                   power_down,
  output logic                   irq,
  output logic                   ed_low_power,
  output logic                   ed_tx_pulse,
  output logic                   ed_powerup
);
  import pd_irq_pkg::*;

  // pulse width, least time rounded up to whole cycles
  localparam int unsigned WIDTH_RAW =
    (`ED_PULSE_WIDTH_NS * `CLK_MHZ + 999) / 1000;
  localparam int unsigned WIDTH_CYC =
    (WIDTH_RAW < 1) ? 1 : WIDTH_RAW;
  localparam logic [CNT_W-1:0] PERIOD_M1 =
    CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] WIDTH_C  = CNT_W'(WIDTH_CYC);
  localparam logic [CNT_W-1:0] WAKE_M1  = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] IDLE_M1  = CNT_W'(IDLE_CYC - 1);

  // state
  logic [15:0]      basic_ctrl_ff;
  logic [1:0]       irq_ctrl_ff;
  logic [7:0]       irq_mask_ff;
  logic [7:0]       irq_stat_ff;
  logic             ed_en_ff;
  logic [15:0]      rdata_ff;
  logic             pin_s1_ff;
  logic             pin_s2_ff;
  logic             nrg_s1_ff;
  logic             nrg_s2_ff;
  logic             link_q_ff;
  logic             pd_ff;
  logic             pin_oe_ff;
  logic             irq_ff;
  ed_state_t        ed_state_ff;
  logic [CNT_W-1:0] ed_cnt_ff;
  logic [CNT_W-1:0] pulse_cnt_ff;
  logic             lp_ff;
  logic             tx_pulse_ff;
  logic             powerup_ff;

  // next values
  logic [15:0]      nxt_basic_ctrl;
  logic [1:0]       nxt_irq_ctrl;
  logic [7:0]       nxt_irq_mask;
  logic [7:0]       nxt_irq_stat;
  logic             nxt_ed_en;
  logic [15:0]      nxt_rdata;
  logic             nxt_pd;
  logic             nxt_pin_oe;
  logic             nxt_irq;
  ed_state_t        nxt_ed_state;
  logic [CNT_W-1:0] nxt_ed_cnt;
  logic [CNT_W-1:0] nxt_pulse_cnt;
  logic             nxt_lp;
  logic             nxt_tx_pulse;

  // address decode
  wire hit_bc   = (req.addr == `ADDR_BASIC_CTRL);
  wire hit_ic   = (req.addr == `ADDR_IRQ_CTRL);
  wire hit_st   = (req.addr == `ADDR_IRQ_STAT);
  wire hit_ed   = (req.addr == `ADDR_ED_CTRL);
  wire wr_bc    = req.wr & hit_bc;
  wire wr_ic    = req.wr & hit_ic;
  wire wr_st    = req.wr & hit_st;
  wire wr_ed    = req.wr & hit_ed;
  wire rd_st    = req.rd & hit_st;

  // pin function select
  wire int_oe   = irq_ctrl_ff[`IC_OE_BIT];
  wire int_en   = irq_ctrl_ff[`IC_EN_BIT];

  // write data into registers; all live during power-down
  assign nxt_basic_ctrl = wr_bc ? req.wdata : basic_ctrl_ff;
  assign nxt_irq_ctrl   = wr_ic ? req.wdata[1:0] : irq_ctrl_ff;
  assign nxt_irq_mask   = wr_st ? req.wdata[7:0] : irq_mask_ff;
  assign nxt_ed_en      = wr_ed ? req.wdata[`ED_EN_BIT]
                                : ed_en_ff;

  // power-down request: control bit or pin low while it is an input
  wire pin_low  = ~pin_s2_ff & ~int_oe;
  assign nxt_pd = basic_ctrl_ff[`BC_PWRDN_BIT]
                  | pin_low;

  // interrupt events
  wire link_chg = link_up ^ link_q_ff;
  wire ed_chg   = nxt_lp ^ lp_ff;
  logic [7:0] evt;
  always_comb begin
    evt                 = ext_evt;
    evt[`MASK_LINK_BIT] = link_chg;
    evt[`MASK_ED_BIT]   = ed_chg;
  end

  // sticky status: mask gates setting, set wins over any clear
  wire [7:0] st_set = evt & irq_mask_ff;
  wire [7:0] st_clr = rd_st ? 8'hFF
                    : (wr_st ? req.wdata[15:8] : 8'h00);
  assign nxt_irq_stat = st_set
                        | (irq_stat_ff & ~st_clr);

  // pending decision made from next status so the pin follows at once
  wire pend     = |(nxt_irq_stat & irq_mask_ff);
  assign nxt_irq    = pend & nxt_irq_ctrl[`IC_EN_BIT];
  assign nxt_pin_oe = nxt_irq
                      & nxt_irq_ctrl[`IC_OE_BIT];

  // energy-detect state machine
  wire energy   = nrg_s2_ff;
  wire cnt_done_idle = (ed_cnt_ff == IDLE_M1);
  wire cnt_done_wake = (ed_cnt_ff == WAKE_M1);
  always_comb begin
    nxt_ed_state = ed_state_ff;
    nxt_ed_cnt   = ed_cnt_ff + CNT_W'(1);
    case (ed_state_ff)
      ED_NORMAL: begin
        if (!ed_en_ff || energy) begin
          nxt_ed_cnt = '0;
        end else if (cnt_done_idle) begin
          nxt_ed_state = ED_SLEEP;
          nxt_ed_cnt   = '0;
        end
      end
      ED_SLEEP: begin
        nxt_ed_cnt = '0;
        if (!ed_en_ff) begin
          nxt_ed_state = ED_NORMAL;
        end else if (energy) begin
          nxt_ed_state = ED_WAKE;
        end
      end
      ED_WAKE: begin
        if (cnt_done_wake || !ed_en_ff) begin
          nxt_ed_state = ED_NORMAL;
          nxt_ed_cnt   = '0;
        end
      end
      default: begin
        nxt_ed_state = ED_NORMAL;
        nxt_ed_cnt   = '0;
      end
    endcase
  end
  assign nxt_lp = (nxt_ed_state == ED_SLEEP);

  // periodic transmit pulses while energy detect is on, except in the wake state
  wire pulse_run = ed_en_ff & (ed_state_ff != ED_WAKE);
  assign nxt_pulse_cnt = (!pulse_run || pulse_cnt_ff == PERIOD_M1)
                         ? '0
                         : pulse_cnt_ff + CNT_W'(1);
  assign nxt_tx_pulse  = pulse_run
                         & (nxt_pulse_cnt < WIDTH_C);

  // read data mux, unmapped reads return zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (req.rd) begin
      if (hit_bc) begin
        nxt_rdata = basic_ctrl_ff;
      end else if (hit_ic) begin
        nxt_rdata = {14'h0000, irq_ctrl_ff};
      end else if (hit_st) begin
        nxt_rdata = {irq_stat_ff, irq_mask_ff};
      end else if (hit_ed) begin
        nxt_rdata = {ed_en_ff, 14'h0000, lp_ff};
      end
    end
  end

  // pin and line-energy synchronisers; pin idles high as the pull-up holds it, energy idles low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      nrg_s1_ff <= 1'b0;
      nrg_s2_ff <= 1'b0;
    end else if (ce) begin
      pin_s1_ff <= pin_i;
      pin_s2_ff <= pin_s1_ff;
      nrg_s1_ff <= line_energy;
      nrg_s2_ff <= nrg_s1_ff;
    end
  end

  // register file
  always_ff @(posedge clk) begin
    if (!resetn) begin
      basic_ctrl_ff <= `RST_BASIC_CTRL;
      irq_ctrl_ff   <= `RST_IRQ_CTRL;
      irq_mask_ff   <= `RST_IRQ_MASK;
      irq_stat_ff   <= `RST_IRQ_STAT;
      ed_en_ff      <= `RST_ED_EN;
      rdata_ff      <= 16'h0000;
    end else if (ce) begin
      basic_ctrl_ff <= nxt_basic_ctrl;
      irq_ctrl_ff   <= nxt_irq_ctrl;
      irq_mask_ff   <= nxt_irq_mask;
      irq_stat_ff   <= nxt_irq_stat;
      ed_en_ff      <= nxt_ed_en;
      rdata_ff      <= nxt_rdata;
    end
  end

  // pin, power-down and interrupt outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_q_ff <= 1'b0;
      pd_ff     <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else if (ce) begin
      link_q_ff <= link_up;
      pd_ff     <= nxt_pd;
      pin_oe_ff <= nxt_pin_oe;
      irq_ff    <= nxt_irq;
    end
  end

  // energy-detect state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ed_state_ff  <= ED_NORMAL;
      ed_cnt_ff    <= '0;
      pulse_cnt_ff <= '0;
      lp_ff        <= 1'b0;
      tx_pulse_ff  <= 1'b0;
      powerup_ff   <= 1'b0;
    end else if (ce) begin
      ed_state_ff  <= nxt_ed_state;
      ed_cnt_ff    <= nxt_ed_cnt;
      pulse_cnt_ff <= nxt_pulse_cnt;
      lp_ff        <= nxt_lp;
      tx_pulse_ff  <= nxt_tx_pulse;
      powerup_ff   <= (nxt_ed_state == ED_WAKE);
    end
  end

  // outputs straight from flops, pull-up tied on; pin only ever pulled low
  assign rdata        = rdata_ff;
  assign pin_o        = 1'b0 & pin_oe_ff; // open drain, drives low
  assign pin_oe       = pin_oe_ff;
  assign pullup_en    = resetn | ~resetn; // always on
  assign power_down   = pd_ff;
  assign irq          = irq_ff;
  assign ed_low_power = lp_ff;
  assign ed_tx_pulse  = tx_pulse_ff;
  assign ed_powerup   = powerup_ff;

endmodule // powerdown_interrupt_pin_logic

// file: pdirq_host.sv
`timescale 1ns/1ps
// host side of the shared pin: open drain beside the device pull-up
module pdirq_host (
  input  wire logic pin_oe,
  input  wire logic pullup_en,
  input  wire logic host_low,
  output logic      pin
);
  // any party pulling low wins, else the weak pull-up holds high
  assign pin = (pin_oe || host_low) ? 1'b0 : pullup_en;
endmodule // pdirq_host

// file: pdirq_checker.sv
`timescale 1ns/1ps
module pdirq_checker
  import pd_irq_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire pd_irq_pkg::reg_req_t req,
  input wire logic [15:0]          rdata,
  input wire logic                 pin_i,
  input wire logic                 pin_o,
  input wire logic                 pin_oe,
  input wire logic                 pullup_en,
  input wire logic                 link_up,
  input wire logic [7:0]           ext_evt,
  input wire logic                 power_down,
  input wire logic                 irq
);
  logic oe_ff;
  logic bit11_ff;

  // shadow of the output-enable and power-down control bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oe_ff    <= 1'b0;
      bit11_ff <= 1'b0;
    end else if (req.wr && req.addr == 5'h11) begin
      oe_ff <= req.wdata[0];
    end else if (req.wr && req.addr == 5'h00) begin
      bit11_ff <= req.wdata[11];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  pullup_on_a:
    assert property (pullup_en && !pin_o) else $error("pin not open drain");
  rst_quiet_a:
    assert property (disable iff (1'b0) !resetn |=> !irq && !pin_oe
      && rdata == 16'h0000) else $error("outputs busy after reset");
  read_clear_a:
    assert property (req.rd && req.addr == 5'h12 && ext_evt == 8'h00
      && $stable(link_up) |=> !irq) else $error("status read kept irq");
  pd_pin_a:
    assert property ((!oe_ff && !pin_i) [*4] |-> power_down)
      else $error("low pin gave no power-down");
  pd_exit_a:
    assert property ((oe_ff && !bit11_ff) [*2] |-> !power_down)
      else $error("output enable kept power-down");
  bit11_pd_a:
    assert property (bit11_ff |=> power_down) else $error("bit 11 ignored");
  oe_gate_a:
    assert property (!oe_ff [*2] |-> !pin_oe) else $error("pin driven as input");
  oe_irq_a:
    assert property (pin_oe |-> irq) else $error("pin low without irq");
endmodule // pdirq_checker

bind powerdown_interrupt_pin_logic pdirq_checker CHK (.clk(clk),
  .resetn(resetn), .req(req), .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe(pin_oe), .pullup_en(pullup_en), .link_up(link_up),
  .ext_evt(ext_evt), .power_down(power_down), .irq(irq));

// file: powerdown_interrupt_pin_logic_tb_top.sv
`timescale 1ns/1ps
module powerdown_interrupt_pin_logic_tb_top;
  import pd_irq_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, link_up = 0, line_energy = 1;
  logic host_low = 1, rd_d = 0, pin, pin_o, pin_oe, pullup_en, irq;
  logic power_down, ed_low_power, ed_tx_pulse, ed_powerup;
  logic [7:0]  ext_evt = 8'h00, r, e;
  logic [15:0] rdata;
  logic [15:0] q[$];
  reg_req_t    req = '0;
  int          errors = 0, checks_done = 0, cyc = 0, n = 0;

  always #5 clk = ~clk;

  powerdown_interrupt_pin_logic #(.PERIOD_CYC(50), .WAKE_CYC(20),
    .IDLE_CYC(20)) DUT (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
    .rdata(rdata), .pin_i(pin), .pin_o(pin_o), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .link_up(link_up), .line_energy(line_energy),
    .ext_evt(ext_evt), .power_down(power_down), .irq(irq),
    .ed_low_power(ed_low_power), .ed_tx_pulse(ed_tx_pulse),
    .ed_powerup(ed_powerup));
  pdirq_host HOST (.pin_oe(pin_oe), .pullup_en(pullup_en),
    .host_low(host_low), .pin(pin));

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t: level %b not %b", $time, g, x);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t: read %h not %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  // read strobe, expected data noted for the scoreboard
  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    @(posedge clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
    q.push_back(x);
    @(posedge clk) req <= '0;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // scoreboard: read data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk16(rdata, q.pop_front());
    rd_d <= req.rd;
    cyc++;
    if (cyc == 4000) begin
      errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h3c74456b));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle(5);
    chk1(power_down, 1'b1);
    chk1(pin_oe, 1'b0);
    rd(5'h11, 16'h0000);
    rd(5'h12, 16'h0000);
    wr(5'h11, 16'h0003);
    settle(3);
    chk1(power_down, 1'b0);
    @(posedge clk) host_low <= 1'b0;
    wr(5'h12, 16'h0060);
    @(posedge clk) link_up <= ~link_up;
    settle(1);
    chk1(irq, 1'b1);
    chk1(pin, 1'b0);
    rd(5'h12, 16'h2060);
    settle(1);
    chk1(pin, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      e = 8'($urandom);
      wr(5'h12, {8'h00, r});
      @(posedge clk) ext_evt <= e;
      @(posedge clk) ext_evt <= 8'h00;
      rd(5'h12, {e & r & 8'h9F, r});
    end
    wr(5'h12, 16'h0000);
    @(posedge clk) link_up <= ~link_up;
    settle(2);
    chk1(irq, 1'b0);
    rd(5'h12, 16'h0000);
    wr(5'h11, 16'h0001);
    wr(5'h12, 16'h0020);
    @(posedge clk) link_up <= ~link_up;
    settle(2);
    chk1(pin_oe, 1'b0);
    rd(5'h12, 16'h2020);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    wr(5'h00, 16'h0800);
    settle(2);
    chk1(power_down, 1'b1);
    wr(5'h00, 16'h0000);
    wr(5'h1D, 16'h8000);
    @(posedge clk) line_energy <= 1'b0;
    settle(30);
    chk1(ed_low_power, 1'b1);
    rd(5'h1D, 16'h8001);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (ed_tx_pulse === 1'b1) n++;
    end
    chk1(n > 0, 1'b1);
    @(posedge clk) line_energy <= 1'b1;
    settle(4);
    chk1(ed_powerup, 1'b1);
    // clock enable low: a write must leave the irq control register alone
    @(posedge clk) ce <= 1'b0;
    wr(5'h11, 16'h0003);
    @(posedge clk) ce <= 1'b1;
    rd(5'h11, 16'h0001);
    settle(2);
    wrap_up();
  end
endmodule // powerdown_interrupt_pin_logic_tb_top
